// file: rtl/tes_sequencer.sv
// power state, pll lock, clock output and keying of the transmitter
`timescale 1ns/100ps
// Contract
// - with both enables low everything is off in standby.
// - enable high and amplifier low runs oscillator, pll and clock out.
// - the pll locks and clock out is stable within one millisecond.
// - both enables high turn the amplifier on, toggling amp_on keys ask.
// - the vco locks to sixty-four times the crystal oscillator.
// - the clock output runs at a quarter of the crystal frequency.
module tes_sequencer #(
  parameter int LOCK_CYCLES     = tes_pkg::LOCK_CYCLES,
  parameter int TAKEOVER_CYCLES = tes_pkg::TAKEOVER_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     tx_enable,
  input  wire logic                     amp_on,
  input  wire logic                     load_switch_closed,
  output logic                          crystal_osc,
  output logic                          pll_locked,
  output logic                          clk_out,
  output logic                          pa_on,
  output logic                          carrier_low,
  output logic [tes_pkg::VCO_W-1:0]     vco_ratio,
  output logic                          takeover_ok
);
  typedef struct packed {
    tes_pkg::tes_state_e              state;
    logic [tes_pkg::CNT_W-1:0]        cnt;
    logic [tes_pkg::XDIV_W-1:0]       xdiv;
    logic [tes_pkg::QTR_W-1:0]        quarter;
    logic                             osc_run;
    logic                             locked;
    logic                             clk_out;
    logic                             pa_on;
    logic                             carrier_low;
    logic [tes_pkg::VCO_W-1:0]        vco_ratio;
    logic                             takeover_ok;
  } tes_regs_s;

  localparam logic [tes_pkg::CNT_W-1:0] LOCK_LAST =
    tes_pkg::CNT_W'(LOCK_CYCLES - 1);
  localparam logic [tes_pkg::CNT_W-1:0] TAKE_LAST =
    tes_pkg::CNT_W'(TAKEOVER_CYCLES - 1);
  localparam logic [tes_pkg::XDIV_W-1:0] XDIV_LAST =
    tes_pkg::XDIV_W'(tes_pkg::XTAL_DIV - 1);

  tes_regs_s  r_reg;
  tes_regs_s  r_next;
  logic [2:0] pins_s;
  logic       en_s;
  logic       amp_s;
  logic       sw_s;

  // all three lines come from the controller's own clock domain
  tes_sync #(
    .W (3)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({tx_enable, amp_on, load_switch_closed}),
    .q    (pins_s)
  );
  assign en_s  = pins_s[2];
  assign amp_s = pins_s[1];
  assign sw_s  = pins_s[0];

  always_comb begin
    r_next = r_reg;
    unique case (r_reg.state)
      tes_pkg::ST_STANDBY: begin
        r_next.cnt = '0;
        if (en_s) begin
          r_next.state = tes_pkg::ST_LOCKING;
        end
      end
      tes_pkg::ST_LOCKING: begin
        r_next.cnt = r_reg.cnt + 1'b1;
        if (!en_s) begin
          r_next.state = tes_pkg::ST_STANDBY;
        end else if (r_reg.cnt == LOCK_LAST) begin
          r_next.state = tes_pkg::ST_LOCKED;
        end
      end
      tes_pkg::ST_LOCKED: begin
        // counter saturates once the takeover wait has passed
        if (r_reg.cnt != TAKE_LAST) begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
        if (!en_s) begin
          r_next.state = tes_pkg::ST_STANDBY;
        end
      end
      default: begin
        r_next.state = tes_pkg::ST_STANDBY;
      end
    endcase
    if (r_next.state == tes_pkg::ST_STANDBY) begin
      r_next.cnt = '0;
    end
    r_next.osc_run = (r_next.state != tes_pkg::ST_STANDBY);
    r_next.locked  = (r_next.state == tes_pkg::ST_LOCKED);
    // crystal reference modelled as an enable pulse from a divider
    if (!r_next.osc_run) begin
      r_next.xdiv    = '0;
      r_next.quarter = '0;
    end else if (r_reg.xdiv == XDIV_LAST) begin
      r_next.xdiv    = '0;
      r_next.quarter = r_reg.quarter + 1'b1;
    end else begin
      r_next.xdiv = r_reg.xdiv + 1'b1;
    end
    // clock driver held low until lock; the first high phase after lock can still be cut short
    r_next.clk_out = r_next.locked & r_next.quarter[tes_pkg::QTR_W-1];
    r_next.pa_on   = r_next.osc_run & amp_s;
    r_next.carrier_low = r_next.osc_run & sw_s;
    r_next.vco_ratio   = r_next.locked ? tes_pkg::VCO_MULT
                                       : tes_pkg::VCO_IDLE;
    // amplifier is not gated by this flag: keying early is the mcu's fault
    r_next.takeover_ok = r_next.locked & (r_next.cnt == TAKE_LAST);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg <= '{state: tes_pkg::ST_STANDBY, vco_ratio: tes_pkg::VCO_IDLE,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign crystal_osc = r_reg.osc_run;
  assign pll_locked  = r_reg.locked;
  assign clk_out     = r_reg.clk_out;
  assign pa_on       = r_reg.pa_on;
  assign carrier_low = r_reg.carrier_low;
  assign vco_ratio   = r_reg.vco_ratio;
  assign takeover_ok = r_reg.takeover_ok;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_standby_all_off: assert property (
    !en_s && !amp_s |=> !crystal_osc && !pa_on && !clk_out && !pll_locked)
    else $error("standby left something running");

  chk_amp_without_en: assert property (
    !en_s && amp_s |=> !pa_on && !crystal_osc && !clk_out)
    else $error("amplifier on without transmitter enable");

  chk_osc_only_mode: assert property (
    en_s && !amp_s |=> crystal_osc && !pa_on)
    else $error("oscillator mode wrong");

  chk_lock_deadline: assert property (
    r_reg.state == tes_pkg::ST_LOCKING && r_reg.cnt == LOCK_LAST && en_s
    |=> pll_locked && vco_ratio == tes_pkg::VCO_MULT)
    else $error("pll not locked at deadline");

  chk_lock_needs_osc: assert property (
    pll_locked |-> crystal_osc && r_reg.cnt >= LOCK_LAST)
    else $error("lock without oscillator time");

  chk_amp_keying: assert property (
    en_s && $changed(amp_s) ##1 en_s |-> pa_on == $past(amp_s))
    else $error("amplifier does not follow amp_on");

  chk_vco_ratio: assert property (
    pll_locked |-> vco_ratio == tes_pkg::VCO_MULT)
    else $error("vco ratio not sixty-four");

  // dropping the enable cuts a phase short, so such attempts are void
  chk_clk_quarter: assert property (
    disable iff (srst || !en_s)
    $rose(clk_out) && $past(pll_locked)
    |-> clk_out[*6] ##1 !clk_out)
    else $error("clock output high phase not six cycles");

  chk_clk_low_phase: assert property (
    disable iff (srst || !en_s)
    $fell(clk_out) && pll_locked |-> !clk_out[*6] ##1 clk_out)
    else $error("clock output low phase not six cycles");

  chk_clk_before_lock: assert property (
    !pll_locked |-> !clk_out)
    else $error("clock output toggles before lock");

  chk_fsk_switch: assert property (
    en_s |=> carrier_low == $past(sw_s))
    else $error("carrier select does not follow load switch");

  chk_ask_amp_on: assert property (
    en_s && amp_s |=> pa_on && crystal_osc)
    else $error("amplifier not on with both enables high");

  chk_osc_off_quiet: assert property (
    !crystal_osc |-> !pa_on && !carrier_low && !takeover_ok)
    else $error("output active while oscillator off");

  chk_vco_unlocked: assert property (
    !pll_locked |-> vco_ratio == tes_pkg::VCO_IDLE)
    else $error("vco ratio set without lock");

  chk_lock_exact: assert property (
    $rose(pll_locked) |-> r_reg.cnt == tes_pkg::CNT_W'(LOCK_CYCLES))
    else $error("lock not after the lock wait");

  chk_takeover_late: assert property (
    $rose(takeover_ok) |-> pll_locked && r_reg.cnt == TAKE_LAST)
    else $error("takeover flag before the wait ended");

  cov_lock: cover property ($rose(pll_locked));
  cov_ask_key: cover property (pll_locked && $fell(pa_on));
  cov_fsk_low: cover property (pa_on && $rose(carrier_low));
  cov_takeover: cover property ($rose(takeover_ok));
endmodule

// file: rtl/tes_pkg.sv
// shared constants and state encoding of the transmitter enable sequencer
package tes_pkg;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int LOCK_TIME_NS     = 1000000;
  localparam int TAKEOVER_TIME_NS = 4000000;
  // longest time rounds down, least time rounds up
  localparam int LOCK_CYCLES      = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int TAKEOVER_CYCLES  =
    (TAKEOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W            = 20;
  localparam int XTAL_DIV         = 3;
  localparam int XDIV_W           = 2;
  localparam int QTR_W            = 2;
  localparam int VCO_W            = 7;
  localparam logic [6:0] VCO_MULT = 7'h40;
  localparam logic [6:0] VCO_IDLE = 7'h00;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_LOCKING = 2'b01,
    ST_LOCKED  = 2'b10
  } tes_state_e;
endpackage

// file: rtl/tes_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module tes_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// file: bench/tes_ctrl_model.sv
// controller model driving the enable, amplifier and load switch pins
`timescale 1ns/100ps
module tes_ctrl_model (
  input  wire logic clk,
  output logic      tx_enable,
  output logic      amp_on,
  output logic      load_switch_closed
);
  initial begin
    tx_enable          = 1'b0;
    amp_on             = 1'b0;
    load_switch_closed = 1'b0;
  end
  // levels only; callers keep amp_on low through the takeover wait
  task automatic pins(input logic te, input logic ao, input logic ls);
    tx_enable          = te;
    amp_on             = ao;
    load_switch_closed = ls;
  endtask
  // amplifier off first, enable a few cycles later
  task automatic power_down();
    amp_on             = 1'b0;
    load_switch_closed = 1'b0;
    repeat (4) @(posedge clk);
    #1 tx_enable = 1'b0;
  endtask
endmodule

// file: bench/test_tes_sequencer.sv
// testbench of the transmitter enable sequencer
`timescale 1ns/100ps
module test_tes_sequencer;
  localparam int LOCK = 20;
  localparam int TAKE = 80;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  wire        te;
  wire        ao;
  wire        ls;
  logic       osc;
  logic       lck;
  logic       clk_out;
  logic       pa;
  logic       low;
  logic [6:0] vco;
  logic       tko;
  int         miscompares = 0;
  int         check_count = 0;
  wire  [4:0] st = {osc, lck, pa, low, tko};
  always #2 clk = ~clk;
  tes_ctrl_model u_ctrl (.clk(clk), .tx_enable(te), .amp_on(ao),
    .load_switch_closed(ls));
  tes_sequencer #(.LOCK_CYCLES(LOCK), .TAKEOVER_CYCLES(TAKE)) u_dut (
    .clk(clk), .srst(srst), .tx_enable(te), .amp_on(ao),
    .load_switch_closed(ls), .crystal_osc(osc), .pll_locked(lck),
    .clk_out(clk_out), .pa_on(pa), .carrier_low(low), .vco_ratio(vco),
    .takeover_ok(tko));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [6:0] seen, input logic [6:0] exp,
                       input string msg);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_standby();
    u_ctrl.pins(1'b0, 1'b1, 1'b1);
    step(6);
    check(7'({st, clk_out}), 7'h00, "amp without enable");
    check(vco, 7'h00, "vco idle");
    u_ctrl.pins(1'b0, 1'b0, 1'b0);
    step(4);
    $display("standby done");
  endtask
  task automatic t_power_up();
    u_ctrl.pins(1'b1, 1'b0, 1'b0);
    // two sync flops plus the state register: outputs move on edge three
    step(2);
    check(7'(st), 7'h00, "osc early");
    step(1);
    check(7'(st), 7'h10, "osc only");
    step(LOCK - 1);
    check(7'(lck), 7'h0, "lock early");
    step(1);
    check(7'(lck), 7'h1, "lock late");
    check(vco, 7'h40, "vco ratio");
    // flag looks one count ahead, so it rises take - 1 after osc start
    step(TAKE - LOCK - 2);
    check(7'(tko), 7'h0, "takeover early");
    step(1);
    check(7'(st), 7'h19, "takeover state");
    $display("power up done");
  endtask
  task automatic t_clock_out();
    int hi;
    int per;
    hi = 0;
    for (int i = 0; i < 30 && clk_out !== 1'b0; i++) step(1);
    for (int i = 0; i < 30 && clk_out !== 1'b1; i++) step(1);
    while (clk_out === 1'b1 && hi < 30) begin
      hi++;
      step(1);
    end
    per = hi;
    while (clk_out === 1'b0 && per < 60) begin
      per++;
      step(1);
    end
    check(7'(hi), 7'h06, "clock high time");
    check(7'(per), 7'h0c, "clock period");
    $display("clock out done");
  endtask
  task automatic t_keying();
    u_ctrl.pins(1'b1, 1'b1, 1'b0);
    step(2);
    check(7'(pa), 7'h0, "amp early");
    step(1);
    check(7'(pa), 7'h1, "amp on");
    u_ctrl.pins(1'b1, 1'b1, 1'b1);
    step(4);
    check(7'({pa, low}), 7'h3, "switch closed");
    u_ctrl.pins(1'b1, 1'b0, 1'b0);
    step(4);
    check(7'({pa, low}), 7'h0, "switch open");
    $display("keying done");
  endtask
  task automatic t_shutdown();
    u_ctrl.power_down();
    step(2);
    check(7'({osc, pa}), 7'h2, "osc early off");
    step(1);
    check(7'({st, clk_out}), 7'h00, "standby again");
    check(vco, 7'h00, "vco off");
    $display("shutdown done");
  endtask
  initial begin
    step(12);
    srst = 1'b0;
    step(2);
    t_standby();
    t_power_up();
    t_clock_out();
    t_keying();
    t_shutdown();
    end_sim();
  end
  initial begin
    #5000;
    miscompares++;
    end_sim();
  end
endmodule
